// file: vacfc_ctrl.sv
// frequency change sequencing and vco sub-band calibration behind the main serial port
`timescale 1ns/10ps
module vacfc_ctrl #(
	parameter int SW_BITS = 5
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        spi_clk,
	input  wire logic        spi_enable,
	input  wire logic        spi_data_in,
	output logic             spi_data_out,
	input  wire logic        vco_clk_in,
	input  wire logic        lock_detect,
	output logic             vco_port_clock,
	output logic             vco_port_data,
	output logic             vco_port_enable,
	output logic [23:0]      prescaler_int,
	output logic [23:0]      modulator_frac,
	output logic             cal_busy
);
	// the switch index and status field are 3 and 8 bits wide
	if (SW_BITS < 1 || SW_BITS > 8) begin : g_bad_sw
		$error("SW_BITS must be 1..8");
	end

	logic [4:0] pins;
	logic       sck, sen, sdi, vco_lvl, lock_lvl;
	vacfc_sync #(.W(5)) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({spi_clk, spi_enable, spi_data_in, vco_clk_in, lock_detect}),
		.sync_out (pins)
	);
	assign {sck, sen, sdi, vco_lvl, lock_lvl} = pins;

	// serial port and register file
	logic [30:0] shift_reg, shift_next;
	logic [5:0]  bitc_reg, bitc_next;
	logic [23:0] rd_reg, rd_next;
	logic        sck_d_reg, sen_d_reg, vco_d_reg, lock_d_reg;
	logic        sdo_next;
	logic [23:0] ref_reg, ref_next, int_reg, int_next, frac_reg, frac_next;
	logic [23:0] vcow_reg, vcow_next, mode_reg, mode_next, lock_reg, lock_next, cal_reg, cal_next;
	logic [23:0] pre_next, mod_next;
	logic [7:0]  swstat_reg, swstat_next;
	logic        calreq_reg, calreq_next, vpend_reg, vpend_next, armed_reg, armed_next;
	logic        wr_stb, cal_dis, frac_mode, lock_loss;
	logic [5:0]  wr_addr;
	logic [23:0] wr_data, rd_mux;
	logic        cal_take, cal_load, vco_internal_serial_port_direct;
	logic [SW_BITS-1:0] sw_reg;

	assign wr_stb = sen_d_reg && !sen && (bitc_reg == 6'(vacfc_pkg::FRAME_BITS)) && !shift_reg[30];
	assign wr_addr = shift_reg[29:24];
	assign wr_data = shift_reg[23:0];
	assign cal_dis = cal_reg[vacfc_pkg::CAL_DIS_BIT];
	assign frac_mode = mode_reg[vacfc_pkg::MODE_FRAC_BIT];
	assign lock_loss = lock_d_reg && !lock_lvl;

	always_comb begin
		case (shift_reg[5:0])
			vacfc_pkg::ADDR_REF:    rd_mux = ref_reg;
			vacfc_pkg::ADDR_INT:    rd_mux = int_reg;
			vacfc_pkg::ADDR_FRAC:   rd_mux = frac_reg;
			vacfc_pkg::ADDR_VCOW:   rd_mux = vcow_reg;
			vacfc_pkg::ADDR_MODE:   rd_mux = mode_reg;
			vacfc_pkg::ADDR_LOCK:   rd_mux = lock_reg;
			vacfc_pkg::ADDR_CAL:    rd_mux = cal_reg;
			vacfc_pkg::ADDR_SWSTAT: rd_mux = {16'h0000, swstat_reg}; // R21
			default:     rd_mux = 24'h000000;
		endcase
	end

	always_comb begin
		shift_next = shift_reg;
		bitc_next = bitc_reg;
		rd_next = rd_reg;
		sdo_next = spi_data_out;
		ref_next = ref_reg;
		int_next = int_reg;
		frac_next = frac_reg;
		vcow_next = vcow_reg;
		mode_next = mode_reg;
		lock_next = lock_reg;
		cal_next = cal_reg;
		pre_next = prescaler_int;
		mod_next = modulator_frac;
		swstat_next = swstat_reg;
		calreq_next = calreq_reg && !cal_take;
		vpend_next = vpend_reg && !vco_internal_serial_port_direct;
		armed_next = armed_reg;
		if (!sen) begin
			bitc_next = 6'h00;
			sdo_next = 1'b0;
		end else if (sck && !sck_d_reg) begin
			shift_next = {shift_reg[29:0], sdi};
			if (bitc_reg != 6'(vacfc_pkg::FRAME_BITS))
				bitc_next = bitc_reg + 6'h01;
			rd_next = {rd_reg[22:0], 1'b0};
			sdo_next = rd_reg[23];
		end else if (bitc_reg == 6'(vacfc_pkg::RD_AFTER) && shift_reg[6] && sck_d_reg && !sck) begin
			rd_next = rd_mux;
		end
		if (wr_stb) begin
			case (wr_addr)
				vacfc_pkg::ADDR_REF:  ref_next = wr_data;
				vacfc_pkg::ADDR_INT: begin
					int_next = wr_data;
					if (!frac_mode && cal_dis)
						pre_next = wr_data; // R6
					else if (!frac_mode) begin
						calreq_next = 1'b1; // R5 R9
						armed_next = 1'b1;
					end
				end
				vacfc_pkg::ADDR_FRAC: begin
					frac_next = wr_data;
					if (frac_mode && cal_dis) begin
						mod_next = wr_data; // R4
						pre_next = int_reg;
					end else if (frac_mode) begin
						calreq_next = 1'b1; // R3 R9
						armed_next = 1'b1;
					end
				end
				vacfc_pkg::ADDR_VCOW: begin
					vcow_next = wr_data;
					vpend_next = cal_dis; // R20
				end
				vacfc_pkg::ADDR_MODE: mode_next = wr_data;
				vacfc_pkg::ADDR_LOCK: lock_next = wr_data;
				vacfc_pkg::ADDR_CAL:  cal_next = wr_data;
				default:   ;
			endcase
		end
		if (lock_loss && armed_reg && lock_reg[vacfc_pkg::RELOCK_BIT] && !cal_dis) begin
			calreq_next = 1'b1; // R22
			armed_next = 1'b0;
		end
		if (cal_load) begin
			// divider waits for the final switch transfer to finish
			pre_next = int_reg; // R24
			if (frac_mode)
				mod_next = frac_reg;
			swstat_next = 8'(sw_reg); // R21
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= 31'h00000000;
			bitc_reg <= 6'h00;
			rd_reg <= vacfc_pkg::REG_RESET;
			spi_data_out <= 1'b0;
			sck_d_reg <= 1'b0;
			sen_d_reg <= 1'b0;
			vco_d_reg <= 1'b0;
			lock_d_reg <= 1'b0;
			ref_reg <= vacfc_pkg::REF_RESET;
			int_reg <= vacfc_pkg::REG_RESET;
			frac_reg <= vacfc_pkg::REG_RESET;
			vcow_reg <= vacfc_pkg::REG_RESET;
			mode_reg <= vacfc_pkg::REG_RESET;
			lock_reg <= vacfc_pkg::REG_RESET;
			cal_reg <= vacfc_pkg::REG_RESET;
			prescaler_int <= vacfc_pkg::REG_RESET;
			modulator_frac <= vacfc_pkg::REG_RESET;
			swstat_reg <= 8'h00;
			calreq_reg <= 1'b0;
			vpend_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			bitc_reg <= bitc_next;
			rd_reg <= rd_next;
			spi_data_out <= sdo_next;
			sck_d_reg <= sck;
			sen_d_reg <= sen;
			vco_d_reg <= vco_lvl;
			lock_d_reg <= lock_lvl;
			ref_reg <= ref_next;
			int_reg <= int_next;
			frac_reg <= frac_next;
			vcow_reg <= vcow_next;
			mode_reg <= mode_next;
			lock_reg <= lock_next;
			cal_reg <= cal_next;
			prescaler_int <= pre_next;
			modulator_frac <= mod_next;
			swstat_reg <= swstat_next;
			calreq_reg <= calreq_next;
			vpend_reg <= vpend_next;
			armed_reg <= armed_next;
		end
	end

	// calibration state machine
	vacfc_pkg::vacfc_state_t state_reg, state_next;
	logic [SW_BITS-1:0] sw_next;
	logic [2:0]  idx_reg, idx_next;
	logic [4:0]  div_reg, div_next, div_last;
	logic [8:0]  wait_reg, wait_next;
	logic [31:0] win_reg, win_next, cnt_reg, cnt_next, cnt_final, target, window;
	logic [55:0] ratio_sh;
	logic [2:0]  meas_n;
	logic        tick, vco_edge, vco_internal_serial_port_start, vco_internal_serial_port_busy, vco_internal_serial_port_done, busy_next;
	logic [15:0] vco_internal_serial_port_word;

	assign meas_n = cal_reg[vacfc_pkg::CAL_N_LSB +: 3];
	assign vco_edge = vco_lvl && !vco_d_reg;
	// measurement is one window of R * 2^n reference cycles
	assign window = 32'(ref_reg) << meas_n; // R10 R14
	assign ratio_sh = {8'h00, int_reg, frac_reg} << meas_n; // R11
	assign target = ratio_sh[vacfc_pkg::FRAC_BITS +: 32]; // R12 R13
	assign cnt_final = cnt_reg + 32'(vco_edge);
	assign tick = (div_reg == div_last);
	assign cal_take = (state_reg == vacfc_pkg::ST_IDLE) && calreq_reg && !vco_internal_serial_port_busy;
	assign vco_internal_serial_port_direct = (state_reg == vacfc_pkg::ST_IDLE) && !calreq_reg && vpend_reg && !vco_internal_serial_port_busy;
	assign cal_load = (state_reg == vacfc_pkg::ST_LOAD);
	assign vco_internal_serial_port_word = vco_internal_serial_port_direct ? vcow_reg[15:0]
		: {{(vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_BITS - vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_ID_W - SW_BITS){1'b0}}, sw_next,
			vcow_reg[vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_ID_W-1:0]};

	always_comb begin
		case (cal_reg[vacfc_pkg::CAL_DIV_LSB +: 2]) // R1
			2'h0:    div_last = vacfc_pkg::DIV_LAST_M0;
			2'h1:    div_last = vacfc_pkg::DIV_LAST_M2;
			2'h2:    div_last = vacfc_pkg::DIV_LAST_M4;
			default: div_last = vacfc_pkg::DIV_LAST_M5;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		sw_next = sw_reg;
		idx_next = idx_reg;
		div_next = tick ? 5'h00 : div_reg + 5'h01; // R1
		wait_next = wait_reg;
		win_next = win_reg;
		cnt_next = cnt_reg;
		vco_internal_serial_port_start = vco_internal_serial_port_direct; // R20
		busy_next = cal_busy;
		case (state_reg)
			vacfc_pkg::ST_IDLE: begin
				if (cal_take) begin
					sw_next = {1'b1, {(SW_BITS-1){1'b0}}}; // R23
					idx_next = 3'(SW_BITS - 1);
					vco_internal_serial_port_start = 1'b1;
					busy_next = 1'b1;
					state_next = vacfc_pkg::ST_SEND;
				end
			end
			vacfc_pkg::ST_SEND: begin
				if (vco_internal_serial_port_done) begin
					wait_next = {cal_reg[vacfc_pkg::CAL_K_LSB +: 2], 7'h00}; // R16
					state_next = vacfc_pkg::ST_WAIT;
				end
			end
			vacfc_pkg::ST_WAIT: begin
				if (wait_reg == 9'h000) begin
					win_next = window;
					cnt_next = 32'h00000000;
					state_next = vacfc_pkg::ST_MEAS;
				end else if (tick) begin
					wait_next = wait_reg - 9'h001;
				end
			end
			vacfc_pkg::ST_MEAS: begin
				win_next = win_reg - 32'h00000001;
				cnt_next = cnt_final;
				if (win_reg <= 32'h00000001) begin
					// too slow means too much capacitance: drop this bit
					if (cnt_final <= target)
						sw_next[idx_reg] = 1'b0; // R23
					if (idx_reg == 3'h0) begin
						state_next = vacfc_pkg::ST_FINAL;
					end else begin
						sw_next[idx_reg - 3'h1] = 1'b1;
						idx_next = idx_reg - 3'h1;
						state_next = vacfc_pkg::ST_SEND;
					end
					vco_internal_serial_port_start = 1'b1; // R15
				end
			end
			vacfc_pkg::ST_FINAL: begin
				if (vco_internal_serial_port_done)
					state_next = vacfc_pkg::ST_LOAD; // R24
			end
			vacfc_pkg::ST_LOAD: begin
				busy_next = 1'b0;
				state_next = vacfc_pkg::ST_IDLE;
			end
			default: state_next = vacfc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= vacfc_pkg::ST_IDLE;
			sw_reg <= '0;
			idx_reg <= 3'h0;
			div_reg <= 5'h00;
			wait_reg <= 9'h000;
			win_reg <= 32'h00000000;
			cnt_reg <= 32'h00000000;
			cal_busy <= 1'b0;
		end else begin
			state_reg <= state_next;
			sw_reg <= sw_next;
			idx_reg <= idx_next;
			div_reg <= div_next;
			wait_reg <= wait_next;
			win_reg <= win_next;
			cnt_reg <= cnt_next;
			cal_busy <= busy_next;
		end
	end

	vacfc_vco_internal_serial_port u_vco_internal_serial_port (
		.clk         (clk),
		.reset_n     (reset_n),
		.tick        (tick),
		.start       (vco_internal_serial_port_start),
		.word        (vco_internal_serial_port_word),
		.port_clock  (vco_port_clock),
		.port_data   (vco_port_data),
		.port_enable (vco_port_enable),
		.busy        (vco_internal_serial_port_busy),
		.done        (vco_internal_serial_port_done)
	);

	tick_div_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
		tick && cal_reg[14:13] == 2'h1 && !sen && !sen_d_reg |=> !tick [*3] ##1 tick)
		else $error("tick spacing wrong for m=2");
	frac_defer_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
		wr_stb && wr_addr == vacfc_pkg::ADDR_FRAC && frac_mode && !cal_dis |=> $stable(modulator_frac))
		else $error("fractional value loaded before calibration");
	frac_now_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
		wr_stb && wr_addr == vacfc_pkg::ADDR_FRAC && frac_mode && cal_dis |=> modulator_frac == $past(wr_data))
		else $error("fractional value not applied at once");
	int_now_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
		wr_stb && wr_addr == vacfc_pkg::ADDR_INT && !frac_mode && cal_dis |=> prescaler_int == $past(wr_data))
		else $error("integer value not applied at once");
	cal_start_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
		cal_take |=> cal_busy && state_reg == vacfc_pkg::ST_SEND && vco_internal_serial_port_busy)
		else $error("calibration did not start");
	meas_win_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
		state_reg == vacfc_pkg::ST_WAIT && state_next == vacfc_pkg::ST_MEAS |=> win_reg == $past(window))
		else $error("window length wrong");
	sar_bit_a: assert property (@(posedge clk) disable iff (!reset_n) // R23
		state_reg == vacfc_pkg::ST_MEAS && win_reg <= 32'h00000001 && cnt_final <= target
		|=> sw_reg[$past(idx_reg)] == 1'b0) else $error("switch bit kept when slow");
	load_order_a: assert property (@(posedge clk) disable iff (!reset_n) // R24
		cal_load |-> $past(vco_internal_serial_port_done) && !vco_internal_serial_port_busy) else $error("divider loaded before transfer");
	sw_status_a: assert property (@(posedge clk) disable iff (!reset_n) // R21
		cal_load |=> swstat_reg == 8'($past(sw_reg))) else $error("switch status not updated");
endmodule

// file: vacfc_pkg.sv
// constants and types for the vco auto-calibration frequency change controller
// Behaviour
// (R1) state machine clock is reference divided by 2^m, m in 0,2,4,5 by field.
// (R2) host keeps state machine clock at or below 50 MHz.
// (R3) fractional mode, calibration on: fractional write calibrates, then loads modulator.
// (R4) fractional mode, calibration off: fractional write reaches modulator at once, switches untouched.
// (R5) integer mode, calibration on: integer write calibrates, then loads prescaler.
// (R6) integer mode, calibration off: integer write reaches prescaler at once.
// (R7) host writes integer only if changed, then vco port, always fractional last.
// (R8) host writes vco port when needed, then integer register, in integer mode.
// (R9) rewriting the frequency with the same value reruns calibration, same result.
// (R10) measurement window lasts reference period times R times 2^n.
// (R11) divide ratio is integer value plus fractional value over 2^24.
// (R12) target count is floor of ratio times 2^n, compared with counted cycles.
// (R13) per detector cycle the expected count is the ratio rounded down.
// (R14) resolution is about detector rate over 2^(n+1).
// (R15) five switch bits need five measurements and 20-cycle serial transfers.
// (R16) each measurement waits k blocks of 128 state machine cycles.
// (R17) host picks resolution finer than one eighth of a sub-band step.
// (R18) host keeps ratio at least 16 integer, 20.0 fractional, detector under 100 MHz.
// (R19) state machine clock also clocks the 16-bit internal vco serial port.
// (R20) calibration off: vco port write is sent at once in 16 port clocks.
// (R21) chosen switch setting is readable in an eight-bit status field.
// (R22) with auto-relock set, loss of lock reruns calibration exactly once.
// (R23) switch setting is found by successive approximation, one bit per measurement.
// (R24) final switch setting is sent before the pending divider value loads.
package vacfc_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int FRAME_BITS = 31;
	localparam int RD_AFTER = 7;
	localparam logic [5:0] ADDR_REF = 6'h02;
	localparam logic [5:0] ADDR_INT = 6'h03;
	localparam logic [5:0] ADDR_FRAC = 6'h04;
	localparam logic [5:0] ADDR_VCOW = 6'h05;
	localparam logic [5:0] ADDR_MODE = 6'h06;
	localparam logic [5:0] ADDR_LOCK = 6'h07;
	localparam logic [5:0] ADDR_CAL = 6'h0a;
	localparam logic [5:0] ADDR_SWSTAT = 6'h10;
	localparam int MODE_FRAC_BIT = 11;
	localparam int CAL_DIS_BIT = 11;
	localparam int CAL_DIV_LSB = 13;
	localparam int CAL_K_LSB = 6;
	localparam int CAL_N_LSB = 0;
	localparam int RELOCK_BIT = 13;
	localparam int FRAC_BITS = 24;
	localparam int WAIT_SHIFT = 7;
	localparam int VCO_INTERNAL_SERIAL_PORT_BITS = 16;
	localparam int VCO_INTERNAL_SERIAL_PORT_CYCLES = 20;
	localparam int VCO_INTERNAL_SERIAL_PORT_ID_W = 7;
	localparam logic [23:0] REG_RESET = 24'h000000;
	localparam logic [23:0] REF_RESET = 24'h000001;
	localparam logic [4:0] DIV_LAST_M0 = 5'h00;
	localparam logic [4:0] DIV_LAST_M2 = 5'h03;
	localparam logic [4:0] DIV_LAST_M4 = 5'h0f;
	localparam logic [4:0] DIV_LAST_M5 = 5'h1f;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SEND  = 3'h1,
		ST_WAIT  = 3'h2,
		ST_MEAS  = 3'h3,
		ST_FINAL = 3'h4,
		ST_LOAD  = 3'h5
	} vacfc_state_t;
endpackage

// file: vacfc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module vacfc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_out <= sync_next;
		end
	end
endmodule

// file: vacfc_vco_internal_serial_port.sv
// internal 16-bit vco serial port, stepped by the state machine tick
`timescale 1ns/10ps
module vacfc_vco_internal_serial_port (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        tick,
	input  wire logic        start,
	input  wire logic [15:0] word,
	output logic             port_clock,
	output logic             port_data,
	output logic             port_enable,
	output logic             busy,
	output logic             done
);
	logic [15:0] sh_reg, sh_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic        clock_next, data_next, enable_next, busy_next, done_next;

	always_comb begin
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		clock_next = 1'b0;
		data_next = port_data;
		enable_next = port_enable;
		busy_next = busy;
		done_next = 1'b0;
		if (!busy && start) begin
			sh_next = word;
			cnt_next = 5'h00;
			data_next = word[15];
			enable_next = 1'b1;
			busy_next = 1'b1;
		end else if (busy) begin
			if (port_clock) begin
				// data moves only after the strobe, so it is stable around it
				sh_next = {sh_reg[14:0], 1'b0};
				data_next = sh_reg[14];
			end
			if (tick) begin
				clock_next = (cnt_reg < 5'(vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_BITS)); // R19
				cnt_next = cnt_reg + 5'h01;
				if (cnt_reg == 5'(vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_BITS))
					enable_next = 1'b0;
				if (cnt_reg == 5'(vacfc_pkg::VCO_INTERNAL_SERIAL_PORT_CYCLES - 1)) begin // R15
					busy_next = 1'b0;
					done_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_reg <= 16'h0000;
			cnt_reg <= 5'h00;
			port_clock <= 1'b0;
			port_data <= 1'b0;
			port_enable <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			port_clock <= clock_next;
			port_data <= data_next;
			port_enable <= enable_next;
			busy <= busy_next;
			done <= done_next;
		end
	end

	clk_in_frame_a: assert property (@(posedge clk) disable iff (!reset_n) // R19
		port_clock |-> port_enable && busy) else $error("vco port clock outside frame");
endmodule

// file: vacfc_host.sv
// host model that programs the controller over the main serial port
`timescale 1ns/10ps
module vacfc_host (
	input  wire logic clk,
	output logic      spi_clk,
	output logic      spi_enable,
	output logic      spi_data_in,
	input  wire logic spi_data_out
);
	initial begin
		spi_clk = 1'b0;
		spi_enable = 1'b0;
		spi_data_in = 1'b0;
	end

	// each pin phase lasts 4 clk, above the 2 clk delay of the synchronisers
	task automatic frame(input logic rd, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
		logic [30:0] w;
		w = {rd, a, d};
		q = 24'h000000;
		@(posedge clk);
		spi_enable <= 1'b1;
		for (int b = 0; b < 32; b++) begin
			@(posedge clk);
			spi_clk <= 1'b0;
			if (b < 31)
				spi_data_in <= w[30-b];
			repeat (3) @(posedge clk);
			@(negedge clk);
			// read bits settle well before the next rise
			if (b >= 8)
				q = {q[22:0], spi_data_out};
			@(posedge clk);
			if (b < 31)
				spi_clk <= 1'b1;
			repeat (3) @(posedge clk);
		end
		spi_enable <= 1'b0;
		// released line must not keep showing the last bit
		spi_data_in <= ~spi_data_in;
		repeat (8) @(posedge clk);
	endtask
endmodule

// file: tb_top.sv
// self-checking bench for the frequency change controller
`timescale 1ns/10ps
module tb_top;
	logic        clk;
	logic        reset_n = 1'b0;
	logic        spi_clk;
	logic        spi_enable;
	logic        spi_data_in;
	logic        spi_data_out;
	logic        vco_clk_in = 1'b0;
	logic        lock_detect = 1'b1;
	logic        vco_port_clock;
	logic        vco_port_data;
	logic        vco_port_enable;
	logic [23:0] prescaler_int;
	logic [23:0] modulator_frac;
	logic        cal_busy;
	logic [15:0] sh = 16'h0000;
	logic [15:0] last_word = 16'h0000;
	logic [4:0]  cur_sw = 5'h00;
	logic [23:0] q;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          vco_cnt = 0;
	int          nbit = 0;
	int          n_xfer = 0;
	int          span = 0;
	int          t_first = 0;
	int          dur[5];
	int          mexp[4] = '{0, 2, 4, 5};

	vacfc_ctrl #(.SW_BITS(5)) dut_u (.clk(clk), .reset_n(reset_n), .spi_clk(spi_clk), .spi_enable(spi_enable),
		.spi_data_in(spi_data_in), .spi_data_out(spi_data_out), .vco_clk_in(vco_clk_in),
		.lock_detect(lock_detect), .vco_port_clock(vco_port_clock), .vco_port_data(vco_port_data),
		.vco_port_enable(vco_port_enable), .prescaler_int(prescaler_int), .modulator_frac(modulator_frac),
		.cal_busy(cal_busy));
	vacfc_host host_u (.clk(clk), .spi_clk(spi_clk), .spi_enable(spi_enable), .spi_data_in(spi_data_in),
		.spi_data_out(spi_data_out));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// vco stand-in: half period 2+switch clk, so a higher switch gives a lower frequency
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (vco_cnt >= 1 + int'(cur_sw)) begin
			vco_cnt <= 0;
			vco_clk_in <= ~vco_clk_in;
		end else
			vco_cnt <= vco_cnt + 1;
		// a strobe outside the enable window is not taken, so a missing enable shows as a lost word
		if (vco_port_clock && vco_port_enable) begin
			sh <= {sh[14:0], vco_port_data};
			if (nbit == 0)
				t_first <= cyc;
			if (nbit == 15) begin
				last_word <= {sh[14:0], vco_port_data};
				cur_sw <= sh[10:6];
				n_xfer <= n_xfer + 1;
				span <= cyc - t_first;
				nbit <= 0;
			end else
				nbit <= nbit + 1;
		end
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		host_u.frame(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a);
		host_u.frame(1'b1, a, 24'h000000, q);
	endtask

	// successive approximation over the stand-in, window of 256 clk
	function automatic logic [4:0] exp_sw(input int target);
		logic [4:0] s;
		logic [4:0] t;
		s = 5'h00;
		for (int b = 4; b >= 0; b--) begin
			t = s | (5'h01 << b);
			if (256 / (2 * (2 + int'(t))) > target)
				s = t;
		end
		return s;
	endfunction

	function automatic logic [23:0] near(input int a, input int e, input int tol);
		return (a - e <= tol && e - a <= tol) ? 24'h000001 : 24'h000000;
	endfunction

	// divider outputs must not move while calibration runs
	task automatic run_cal(output int d);
		logic [23:0] p;
		logic [23:0] m;
		@(negedge clk);
		p = prescaler_int;
		m = modulator_frac;
		d = 0;
		chk({23'h000000, cal_busy}, 24'h000001);
		while (cal_busy === 1'b1 && d < 20000) begin
			chk((prescaler_int ^ p) | (modulator_frac ^ m), 24'h000000);
			@(negedge clk);
			d++;
		end
		if (d >= 20000) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic t_reset;
		chk(prescaler_int, 24'h000000);
		chk(modulator_frac, 24'h000000);
		rd(vacfc_pkg::ADDR_REF);
		chk(q, vacfc_pkg::REF_RESET);
		rd(vacfc_pkg::ADDR_SWSTAT);
		chk(q, 24'h000000);
		rd(6'h3f);
		chk(q, 24'h000000);
	endtask

	task automatic t_manual;
		int x;
		x = n_xfer;
		wr(vacfc_pkg::ADDR_CAL, 24'h000800);
		wr(vacfc_pkg::ADDR_INT, 24'h000123);
		chk(prescaler_int, 24'h000123);
		wr(vacfc_pkg::ADDR_MODE, 24'h000800);
		wr(vacfc_pkg::ADDR_FRAC, 24'h000456);
		chk(modulator_frac, 24'h000456);
		chk(24'(n_xfer - x), 24'h000000);
		wr(vacfc_pkg::ADDR_VCOW, 24'h00a5c3);
		repeat (30) @(negedge clk);
		chk(24'(n_xfer - x), 24'h000001);
		chk({8'h00, last_word}, 24'h00a5c3);
		chk(24'(span), 24'h00000f);
		wr(vacfc_pkg::ADDR_MODE, 24'h000000);
	endtask

	task automatic t_cal_int;
		int x;
		int d;
		wr(vacfc_pkg::ADDR_CAL, 24'h000000);
		wr(vacfc_pkg::ADDR_REF, 24'h000100);
		wr(vacfc_pkg::ADDR_VCOW, 24'h000055);
		// second pass rewrites the same value
		for (int i = 0; i < 2; i++) begin
			x = n_xfer;
			wr(vacfc_pkg::ADDR_INT, 24'h00001c);
			run_cal(d);
			chk(prescaler_int, 24'h00001c);
			chk(24'(n_xfer - x), 24'h000006);
			chk({8'h00, last_word}, {12'h000, exp_sw(28), 7'h55});
			rd(vacfc_pkg::ADDR_SWSTAT);
			chk(q, {19'h00000, exp_sw(28)});
		end
	endtask

	task automatic t_cal_frac;
		int d;
		wr(vacfc_pkg::ADDR_MODE, 24'h000800);
		wr(vacfc_pkg::ADDR_INT, 24'h000014);
		chk(prescaler_int, 24'h00001c);
		wr(vacfc_pkg::ADDR_VCOW, 24'h000055);
		wr(vacfc_pkg::ADDR_FRAC, 24'h800000);
		run_cal(d);
		chk(modulator_frac, 24'h800000);
		chk(prescaler_int, 24'h000014);
		chk({8'h00, last_word}, {12'h000, exp_sw(20), 7'h55});
	endtask

	task automatic t_timing;
		for (int c = 0; c < 4; c++) begin
			wr(vacfc_pkg::ADDR_CAL, 24'(c) << 13);
			wr(vacfc_pkg::ADDR_FRAC, 24'h800000);
			run_cal(dur[c]);
			chk(24'(span), 24'(15 << mexp[c]));
		end
		wr(vacfc_pkg::ADDR_CAL, 24'h000040);
		wr(vacfc_pkg::ADDR_FRAC, 24'h800000);
		run_cal(dur[4]);
		chk(near(dur[4] - dur[0], 640, 4), 24'h000001);
		// tick phase alignment blurs each step by up to one tick
		for (int c = 1; c < 4; c++)
			chk(near(dur[c] - dur[0], 120 * ((1 << mexp[c]) - 1), 8 << mexp[c]), 24'h000001);
		wr(vacfc_pkg::ADDR_CAL, 24'h000000);
	endtask

	task automatic t_relock;
		int d;
		wr(vacfc_pkg::ADDR_LOCK, 24'h002000);
		wr(vacfc_pkg::ADDR_FRAC, 24'h800000);
		run_cal(d);
		@(posedge clk);
		lock_detect <= 1'b0;
		repeat (10) @(posedge clk);
		run_cal(d);
		lock_detect <= 1'b1;
		repeat (10) @(posedge clk);
		lock_detect <= 1'b0;
		repeat (10) @(negedge clk);
		chk({23'h000000, cal_busy}, 24'h000000);
		@(posedge clk);
		lock_detect <= 1'b1;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_manual();
		t_cal_int();
		t_cal_frac();
		t_timing();
		t_relock();
		stop_test();
	end
endmodule
